// ### hdl/adc_seq.sv
// Sample and convert sequencer with an APB register slave.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

module adc_seq #(
    parameter int RES_W = 12
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RC_TICK,
    input wire adc_seq_pkg::trig_in_t TRIG,
    input wire logic [RES_W-1:0] ANALOG_CODE,
    output logic SH_CONNECT,
    output logic CONVERTING,
    output logic [RES_W-1:0] RESULT,
    output logic CONVERTER_IRQ
);

    // ************************************************************
    // Registers and state.
    // ************************************************************
    logic sample_request_q, done_q, auto_sample_enable_q, converter_on_q;
    logic offset_calibrate_q, converter_irq_enable_q, rc_clock_select_q;
    logic edge_falling_q, autoscan_enable_q, converter_irq_flag_q;
    logic [1:0] autoscan_irq_mode_q, rc_sync_q;
    logic [2:0] pin_sync_q, cmp_sync_q;
    logic [3:0] trigger_source_select_q, conv_cnt_q;
    logic [4:0] conversions_per_irq_q, sample_time_count_q;
    logic [4:0] smp_cnt_q, seq_cnt_q;
    logic [7:0] clock_prescale_select_q, pre_cnt_q;
    logic [RES_W-1:0] result_q;
    adc_seq_pkg::seq_state_t state_q;

    logic wr_en, rd_en, mapped, tad, pin_edge, cmp_edge;
    logic trig_hit, conv_end, conv_start, irq_event;
    logic sw_sample_request_set, sw_sample_request_clr;

    // All assertions below share this clock and this reset.
    default clocking sys_cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // ************************************************************
    // APB slave: zero wait states while CE is high (PREADY follows CE), error on unmapped addresses.
    // ************************************************************
    assign wr_en = PSEL && PENABLE && PWRITE && CE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    assign PREADY = CE;
    assign mapped = (PADDR == `OFS_CTRL1) || (PADDR == `OFS_CTRL2) ||
        (PADDR == `OFS_CTRL3) || (PADDR == `OFS_CTRL5) ||
        (PADDR == `OFS_RESULT) || (PADDR == `OFS_STATUS);
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // Read mux; reserved bits read as zero.
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (rd_en) begin
            case (PADDR)
                `OFS_CTRL1: begin
                    PRDATA[`C1_DONE] = done_q;
                    PRDATA[`C1_SAMPLE_REQUEST] = sample_request_q;
                    PRDATA[`C1_AUTO_SAMPLE_ENABLE] = auto_sample_enable_q;
                    PRDATA[7:4] = trigger_source_select_q;
                    PRDATA[8 + `C1_ON] = converter_on_q;
                end
                `OFS_CTRL2: begin
                    PRDATA[6:2] = conversions_per_irq_q;
                    PRDATA[8 + `C2_OFFSET_CALIBRATE] = offset_calibrate_q;
                    PRDATA[16 + 0] = converter_irq_enable_q;
                end
                `OFS_CTRL3: begin
                    PRDATA[7:0] = clock_prescale_select_q;
                    PRDATA[12:8] = sample_time_count_q;
                    PRDATA[15] = rc_clock_select_q;
                    PRDATA[16] = edge_falling_q;
                end
                `OFS_CTRL5: begin
                    PRDATA[`C5_ASCAN] = autoscan_enable_q;
                    PRDATA[9:8] = autoscan_irq_mode_q;
                end
                `OFS_RESULT: PRDATA[RES_W-1:0] = result_q;
                `OFS_STATUS: PRDATA[0] = converter_irq_flag_q;
                default: PRDATA = 32'h0000_0000;
            endcase
        end
    end

    // Software edges on the sample request bit.
    assign sw_sample_request_set = wr_en && (PADDR == `OFS_CTRL1) &&
        PWDATA[`C1_SAMPLE_REQUEST] && !sample_request_q;
    assign sw_sample_request_clr = wr_en && (PADDR == `OFS_CTRL1) &&
        !PWDATA[`C1_SAMPLE_REQUEST] && sample_request_q;

    // Configuration registers; they keep their values while off.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            auto_sample_enable_q <= 1'b0;
            trigger_source_select_q <= 4'h0;
            converter_on_q <= 1'b0;
            conversions_per_irq_q <= 5'h00;
            offset_calibrate_q <= 1'b0;
            converter_irq_enable_q <= 1'b0;
            sample_time_count_q <= 5'h01;
            clock_prescale_select_q <= 8'h00;
            rc_clock_select_q <= 1'b0;
            edge_falling_q <= 1'b0;
            autoscan_enable_q <= 1'b0;
            autoscan_irq_mode_q <= 2'h0;
        end else if (wr_en) begin
            case (PADDR)
                `OFS_CTRL1: begin
                    auto_sample_enable_q <= PWDATA[`C1_AUTO_SAMPLE_ENABLE];
                    trigger_source_select_q <= PWDATA[7:4];
                    converter_on_q <= PWDATA[8 + `C1_ON];
                end
                `OFS_CTRL2: begin
                    conversions_per_irq_q <= PWDATA[6:2];
                    offset_calibrate_q <= PWDATA[8 + `C2_OFFSET_CALIBRATE];
                    converter_irq_enable_q <= PWDATA[16];
                end
                `OFS_CTRL3: begin
                    clock_prescale_select_q <= PWDATA[7:0];
                    sample_time_count_q <= PWDATA[12:8];
                    rc_clock_select_q <= PWDATA[15];
                    edge_falling_q <= PWDATA[16];
                end
                `OFS_CTRL5: begin
                    autoscan_enable_q <= PWDATA[`C5_ASCAN];
                    autoscan_irq_mode_q <= PWDATA[9:8];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Converter clock: one-cycle TAD tick from RC or prescaler.
    // ************************************************************
    // TAD lasts prescale+1 system clocks; RC tick is an async pin.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pre_cnt_q <= 8'h00;
            rc_sync_q <= 2'b00;
        end else if (CE) begin
            rc_sync_q <= {rc_sync_q[0], RC_TICK};
            if (conv_start || pre_cnt_q >= clock_prescale_select_q) begin
                pre_cnt_q <= 8'h00;
            end else begin
                pre_cnt_q <= pre_cnt_q + 8'h01;
            end
        end
    end

    assign tad = rc_clock_select_q ? rc_sync_q[1] :
        (pre_cnt_q >= clock_prescale_select_q);

    // ************************************************************
    // Trigger synchronisers and edge detectors.
    // ************************************************************
    // Stage 0 feeds only stage 1; edges are taken between 1 and 2.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pin_sync_q <= 3'b000;
            cmp_sync_q <= 3'b000;
        end else if (CE) begin
            pin_sync_q <= {pin_sync_q[1:0], TRIG.pin};
            cmp_sync_q <= {cmp_sync_q[1:0], TRIG.compare};
        end
    end

    assign pin_edge = edge_falling_q ?
        (!pin_sync_q[1] && pin_sync_q[2]) :
        (pin_sync_q[1] && !pin_sync_q[2]);
    assign cmp_edge = cmp_sync_q[1] && !cmp_sync_q[2];

    // Hardware trigger that ends acquisition for the event sources.
    // A pulse seen outside sampling is dropped, not queued.
    always_comb begin
        case (trigger_source_select_q)
            `SRC_PIN: trig_hit = pin_edge;
            `SRC_COMPARE: trig_hit = cmp_edge;
            `SRC_CLOCKED: trig_hit = tad &&
                (smp_cnt_q + 5'h01 >= sample_time_count_q);
            default: trig_hit = 1'b0;
        endcase
    end

    assign conv_end = (state_q == adc_seq_pkg::ST_CONVERT) && tad &&
        (conv_cnt_q == `CONV_TAD - 4'h1);

    // Start of conversion. The prescaler restarts here, otherwise a
    // conversion begun mid-period would be short of twelve whole TADs.
    assign conv_start = converter_on_q && CE &&
        (state_q == adc_seq_pkg::ST_SAMPLE) && (sw_sample_request_clr || trig_hit);

    // ************************************************************
    // Sequencer.
    // ************************************************************
    // A write that clears sample request and a hardware trigger act
    // the same way; disabling the converter wins over everything.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= adc_seq_pkg::ST_IDLE;
            sample_request_q <= 1'b0;
            done_q <= 1'b1;
            smp_cnt_q <= 5'h00;
            conv_cnt_q <= 4'h0;
        end else if (CE) begin
            if (!converter_on_q) begin
                // Abort: result left untouched, sequencer idle.
                state_q <= adc_seq_pkg::ST_IDLE;
                sample_request_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                case (state_q)
                    adc_seq_pkg::ST_IDLE: begin
                        if (sw_sample_request_set || auto_sample_enable_q) begin
                            state_q <= adc_seq_pkg::ST_SAMPLE;
                            sample_request_q <= 1'b1;
                            smp_cnt_q <= 5'h00;
                        end
                    end
                    adc_seq_pkg::ST_SAMPLE: begin
                        if (tad) begin
                            smp_cnt_q <= smp_cnt_q + 5'h01;
                        end
                        if (sw_sample_request_clr || trig_hit) begin
                            state_q <= adc_seq_pkg::ST_CONVERT;
                            sample_request_q <= 1'b0;
                            done_q <= 1'b0;
                            conv_cnt_q <= 4'h0;
                        end
                    end
                    adc_seq_pkg::ST_CONVERT: begin
                        if (tad) begin
                            conv_cnt_q <= conv_cnt_q + 4'h1;
                        end
                        if (conv_end) begin
                            done_q <= 1'b1;
                            if (auto_sample_enable_q) begin
                                state_q <= adc_seq_pkg::ST_SAMPLE;
                                sample_request_q <= 1'b1;
                                smp_cnt_q <= 5'h00;
                            end else begin
                                state_q <= adc_seq_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: state_q <= adc_seq_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Result capture; calibration converts the disconnected input.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            result_q <= '0;
        end else if (CE && conv_end && converter_on_q) begin
            result_q <= offset_calibrate_q ? '0 : ANALOG_CODE;
        end
    end

    assign SH_CONNECT = converter_on_q && !offset_calibrate_q &&
        (state_q == adc_seq_pkg::ST_SAMPLE);
    assign CONVERTING = (state_q == adc_seq_pkg::ST_CONVERT);
    assign RESULT = result_q;

    // ************************************************************
    // Interrupt counting.
    // ************************************************************
    // Auto-scan mode 0 suppresses; other modes fire each conversion.
    assign irq_event = conv_end && (autoscan_enable_q ?
        (autoscan_irq_mode_q != 2'h0) :
        (seq_cnt_q == conversions_per_irq_q));

    // Flag set wins over a clearing write in the same cycle.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            seq_cnt_q <= 5'h00;
            converter_irq_flag_q <= 1'b0;
        end else if (CE) begin
            if (conv_end) begin
                seq_cnt_q <= (seq_cnt_q >= conversions_per_irq_q) ?
                    5'h00 : seq_cnt_q + 5'h01;
            end
            if (irq_event) begin
                converter_irq_flag_q <= 1'b1;
            end else if (wr_en && (PADDR == `OFS_STATUS) && PWDATA[0]) begin
                converter_irq_flag_q <= 1'b0;
            end
        end
    end

    assign CONVERTER_IRQ = converter_irq_flag_q &&
        converter_irq_enable_q;

    // ************************************************************
    // Assertions.
    // ************************************************************
    property p_done_low_while_conv;
        (state_q == adc_seq_pkg::ST_CONVERT) |-> !done_q;
    endproperty
    a_done_low_while_conv: assert property (p_done_low_while_conv)
        else $error("done high during conversion");
    property p_conv_end_sets_done;
        (CE && conv_end && converter_on_q) |=> done_q && result_q ==
            ($past(offset_calibrate_q) ? '0 : $past(ANALOG_CODE));
    endproperty
    a_conv_end_sets_done: assert property (p_conv_end_sets_done)
        else $error("done or result not updated at end");
    property p_abort;
        (CE && !converter_on_q) |=> $stable(result_q) &&
            state_q == adc_seq_pkg::ST_IDLE;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not idle or changed result");
    property p_auto_resample;
        (CE && conv_end && converter_on_q && auto_sample_enable_q) |=>
            sample_request_q;
    endproperty
    a_auto_resample: assert property (p_auto_resample)
        else $error("no auto resample");
    property p_manual_stop;
        (CE && conv_end && converter_on_q && !auto_sample_enable_q) |=>
            !sample_request_q && state_q == adc_seq_pkg::ST_IDLE;
    endproperty
    a_manual_stop: assert property (p_manual_stop)
        else $error("restarted without auto sample");
    property p_irq_gate;
        CONVERTER_IRQ |-> converter_irq_enable_q && converter_irq_flag_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable");
    property p_irq_set;
        (CE && irq_event) |=> converter_irq_flag_q;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("irq flag not set");
    property p_manual_trigger;
        (CE && converter_on_q && state_q == adc_seq_pkg::ST_SAMPLE &&
            trigger_source_select_q == `SRC_MANUAL && !sw_sample_request_clr) |=>
            state_q != adc_seq_pkg::ST_CONVERT;
    endproperty
    a_manual_trigger: assert property (p_manual_trigger)
        else $error("conversion without software clear");
    property p_calib_disconnect;
        offset_calibrate_q |-> !SH_CONNECT;
    endproperty
    a_calib_disconnect: assert property (p_calib_disconnect)
        else $error("sample hold connected during calibration");

endmodule

// ### hdl/adc_seq_consts.svh
// Constant definitions for the converter sample/convert sequencer.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ************************************************************
// Register byte offsets on the bus.
// ************************************************************
`define OFS_CTRL1 12'h000
`define OFS_CTRL2 12'h004
`define OFS_CTRL3 12'h008
`define OFS_CTRL5 12'h00c
`define OFS_RESULT 12'h010
`define OFS_STATUS 12'h014

// ************************************************************
// Field positions.
// ************************************************************
`define C1_DONE 0
`define C1_SAMPLE_REQUEST 1
`define C1_AUTO_SAMPLE_ENABLE 2
`define C1_ON 7
`define C1_TRIGGER_SOURCE_SELECT_LO 4
`define C2_CONVERSIONS_PER_IRQ_LO 2
`define C2_OFFSET_CALIBRATE 4
`define C2_IRQ_EN 8
`define C5_ASCAN 7

// ************************************************************
// Trigger source codes and timing.
// ************************************************************
`define SRC_MANUAL 4'h0
`define SRC_PIN 4'h1
`define SRC_COMPARE 4'h2
`define SRC_CLOCKED 4'h7
`define CONV_TAD 4'hc
`define CTRL1_RESET 16'h0001

`endif

// ### hdl/adc_seq_pkg.sv
// Types shared by the converter sequencer.
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } seq_state_t;

    // Trigger inputs grouped as they travel together.
    typedef struct packed {
        logic pin;
        logic compare;
    } trig_in_t;

endpackage

// ### sim/adc_sample_convert_sequencer_tb.sv
// Self-checking bench for the converter sample/convert sequencer.
`timescale 1ns/1ns
`include "adc_seq_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module adc_sample_convert_sequencer_tb;
    typedef struct packed {
        logic [11:0] code;
        logic [7:0] pre;
    } row_t;
    logic clk_sys;
    logic rst;
    logic ce;
    logic psel;
    logic penable;
    logic pwrite;
    logic rc_tick;
    logic pready;
    logic pslverr;
    logic er;
    logic sh_connect;
    logic converting;
    logic converter_irq;
    logic [11:0] paddr;
    logic [11:0] analog_code;
    logic [11:0] result;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    adc_seq_pkg::trig_in_t trig;
    int err_count;
    int cmp_count;
    int sn;
    int cn;
    int i;
    // Ordinary manual conversions: input code and clock prescale.
    row_t rows [3] = '{'{12'h5a5, 8'h00}, '{12'hfff, 8'h01}, '{12'h001, 8'h03}};

    // Free-running system clock, 40 ns period.
    always #20 clk_sys = ~clk_sys;

    adc_seq dut_u (
        .CLK_SYS(clk_sys),
        .RST(rst),
        .CE(ce),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .RC_TICK(rc_tick),
        .TRIG(trig),
        .ANALOG_CODE(analog_code),
        .SH_CONNECT(sh_connect),
        .CONVERTING(converting),
        .RESULT(result),
        .CONVERTER_IRQ(converter_irq)
    );

    // ************************************************************
    // Bus and sequencing helpers.
    // ************************************************************
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task timeout;
        err_count++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, 1);
        conclude;
    endtask

    // One APB transfer; the request holds until PREADY is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 50) timeout;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Counts sampling and converting cycles until a conversion ends.
    task run_conv;
        int n;
        sn = 0;
        cn = 0;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk_sys);
            if (sh_connect === 1'b1) sn++;
            if (converting === 1'b1) cn++;
            else if (cn > 0) break;
        end
        if (n == 3000) timeout;
    endtask

    task manual;
        apb(1'b1, `OFS_CTRL1, 32'h8000);
        apb(1'b1, `OFS_CTRL1, 32'h8002);
        idle(2);
        apb(1'b1, `OFS_CTRL1, 32'h8000);
        run_conv;
    endtask

    task tend(input string s);
        $display("test %s finished", s);
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rc_tick = 1'b0;
        trig = '0;
        analog_code = 12'h000;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(`OFS_CTRL1, {16'h0, `CTRL1_RESET});
        rdchk(`OFS_CTRL3, 32'h100);
        rdchk(`OFS_STATUS, 32'h0);
        apb(1'b0, 12'hff0, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b1, `OFS_CTRL1, 32'h2);
        idle(3);
        `CHK(sh_connect, 1'b0)
        apb(1'b1, `OFS_CTRL1, 32'h0);
        rdchk(`OFS_CTRL1, 32'h1);
        ce <= 1'b0;
        idle(2);
        `CHK(pready, 1'b0)
        ce <= 1'b1;
        tend("reset");
        // Ordinary manual conversions walk the row table.
        for (i = 0; i < 3; i++) begin
            analog_code <= rows[i].code;
            apb(1'b1, `OFS_CTRL3, {19'h0, 5'h01, rows[i].pre});
            apb(1'b1, `OFS_CTRL1, 32'h8000);
            apb(1'b1, `OFS_CTRL1, 32'h8002);
            idle(2);
            `CHK(sh_connect, 1'b1)
            `CHK(converting, 1'b0)
            apb(1'b1, `OFS_CTRL1, 32'h8000);
            run_conv;
            `CHK(cn, 12 * (rows[i].pre + 1))
            `CHK(result, rows[i].code)
            idle(20);
            `CHK(sh_connect, 1'b0)
            rdchk(`OFS_CTRL1, 32'h8001);
            rdchk(`OFS_STATUS, 32'h1);
            `CHK(converter_irq, 1'b0)
            apb(1'b1, `OFS_STATUS, 32'h1);
        end
        tend("rows");
        // Abort in mid-conversion keeps the last result.
        analog_code <= 12'h3c3;
        apb(1'b1, `OFS_CTRL3, 32'h100);
        apb(1'b1, `OFS_CTRL1, 32'h8002);
        apb(1'b1, `OFS_CTRL1, 32'h8000);
        rdchk(`OFS_CTRL1, 32'h8000);
        apb(1'b1, `OFS_CTRL1, 32'h0);
        idle(14);
        `CHK(result, rows[2].code)
        `CHK(converting, 1'b0)
        rdchk(`OFS_CTRL1, 32'h1);
        tend("abort");
        // Clocked trigger, then free running with an interrupt count.
        apb(1'b1, `OFS_CTRL3, 32'h500);
        apb(1'b1, `OFS_CTRL1, 32'h8070);
        apb(1'b1, `OFS_CTRL1, 32'h8072);
        run_conv;
        `CHK(sn, 5)
        apb(1'b1, `OFS_STATUS, 32'h1);
        apb(1'b1, `OFS_CTRL2, 32'h10004);
        apb(1'b1, `OFS_CTRL1, 32'h8076);
        run_conv;
        `CHK(converter_irq, 1'b0)
        run_conv;
        idle(1);
        `CHK(converter_irq, 1'b1)
        `CHK(sh_connect, 1'b1)
        apb(1'b1, `OFS_CTRL1, 32'h8072);
        run_conv;
        `CHK(cn, 12)
        idle(20);
        `CHK(sh_connect | converting, 1'b0)
        apb(1'b1, `OFS_STATUS, 32'h1);
        rdchk(`OFS_STATUS, 32'h0);
        tend("clocked");
        // Autoscan interrupt mode and offset calibration.
        apb(1'b1, `OFS_CTRL1, 32'h0);
        apb(1'b1, `OFS_CTRL2, 32'h0);
        apb(1'b1, `OFS_CTRL5, 32'h80);
        manual;
        rdchk(`OFS_STATUS, 32'h0);
        apb(1'b1, `OFS_CTRL5, 32'h180);
        manual;
        rdchk(`OFS_STATUS, 32'h1);
        apb(1'b1, `OFS_CTRL5, 32'h0);
        apb(1'b1, `OFS_CTRL2, 32'h1000);
        analog_code <= 12'habc;
        apb(1'b1, `OFS_CTRL1, 32'h8002);
        idle(2);
        `CHK(sh_connect, 1'b0)
        apb(1'b1, `OFS_CTRL1, 32'h8000);
        run_conv;
        `CHK(result, 12'h000)
        idle(20);
        `CHK(converting, 1'b0)
        apb(1'b1, `OFS_CTRL2, 32'h0);
        tend("calibrate");
        // RC converter clock: a tick held high is one TAD per clock.
        rc_tick <= 1'b1;
        apb(1'b1, `OFS_CTRL3, 32'h8100);
        manual;
        `CHK(cn, 12)
        rc_tick <= 1'b0;
        apb(1'b1, `OFS_CTRL1, 32'h8002);
        apb(1'b1, `OFS_CTRL1, 32'h8000);
        idle(30);
        `CHK(converting, 1'b1)
        apb(1'b1, `OFS_CTRL1, 32'h0);
        tend("rc clock");
        // Pin trigger on each polarity; a held level converts once.
        for (i = 0; i < 2; i++) begin
            trig.pin <= i[0];
            apb(1'b1, `OFS_CTRL1, 32'h0);
            apb(1'b1, `OFS_CTRL3, {15'h0, i[0], 16'h0100});
            apb(1'b1, `OFS_CTRL1, 32'h8010);
            apb(1'b1, `OFS_CTRL1, 32'h8012);
            idle(3);
            trig.pin <= ~i[0];
            run_conv;
            `CHK(cn, 12)
            apb(1'b1, `OFS_CTRL1, 32'h8012);
            idle(8);
            `CHK(converting, 1'b0)
            trig.pin <= i[0];
            idle(8);
            `CHK(converting, 1'b0)
        end
        tend("pin");
        // Compare events pace auto-sampled conversions.
        apb(1'b1, `OFS_CTRL1, 32'h0);
        apb(1'b1, `OFS_CTRL1, 32'h8026);
        for (i = 0; i < 2; i++) begin
            idle(20);
            `CHK(converting, 1'b0)
            trig.compare <= 1'b1;
            @(posedge clk_sys);
            trig.compare <= 1'b0;
            run_conv;
            `CHK(cn, 12)
        end
        tend("compare");
        // A second reset in mid-run brings back the reset values.
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        `CHK(result, 12'h000)
        `CHK(sh_connect, 1'b0)
        rdchk(`OFS_CTRL1, 32'h1);
        rdchk(`OFS_CTRL3, 32'h100);
        tend("second reset");
        conclude;
    end
endmodule
